// File: shared/rtb_pkg.sv
// Package for the reload timer with baud select: register map, fields,
// reset values and interrupt bit layout.
// Assumes an AXI4-Lite slave with 32-bit data, byte addresses below.
package rtb_pkg;

   localparam int           RTB_AW            = 8;
   localparam logic [7:0]   RTB_OFS_CONTROL   = 8'hC4;
   localparam logic [7:0]   RTB_OFS_RELOAD_LO = 8'hC5;
   localparam logic [7:0]   RTB_OFS_RELOAD_HI = 8'hC6;
   // Word-aligned byte addresses are index times four
   localparam logic [9:0]   RTB_ADDR_CONTROL  = 10'h310;
   localparam logic [9:0]   RTB_ADDR_RELOAD_LO = 10'h314;
   localparam logic [9:0]   RTB_ADDR_RELOAD_HI = 10'h318;
   localparam logic [9:0]   RTB_ADDR_IRQ_STAT = 10'h320;
   localparam logic [9:0]   RTB_ADDR_IRQ_MASK = 10'h324;
   localparam logic [9:0]   RTB_ADDR_ISR_ACK  = 10'h328;

   localparam int           RTB_BIT_PS_LSB    = 0;
   localparam int           RTB_BIT_RUN       = 3;
   localparam int           RTB_BIT_OVF       = 4;
   localparam int           RTB_BIT_BAUD_SRC  = 5;
   localparam int           RTB_BIT_FE_SEL    = 6;
   localparam int           RTB_BIT_DOUBLE    = 7;

   localparam logic [7:0]   RTB_RST_CONTROL   = 8'h00;
   localparam logic [7:0]   RTB_RST_RELOAD    = 8'h00;
   localparam logic [15:0]  RTB_RST_COUNT     = 16'h0000;
   localparam logic [15:0]  RTB_COUNT_MAX     = 16'hFFFF;
   localparam logic [6:0]   RTB_RST_PRESCALE  = 7'h00;

   localparam int           RTB_IRQ_OVF       = 0;
   localparam logic [1:0]   RTB_RST_IRQ       = 2'h0;

   localparam logic [1:0]   RTB_RESP_OKAY     = 2'b00;
   localparam logic [1:0]   RTB_RESP_SLVERR   = 2'b10;

endpackage

// File: rtl/rtb_prescaler.sv
// Power-of-two prescaler producing one tick per selected divisor.
// Assumes a single clock domain; the tick is a one-cycle pulse, except at divisor 1 where it stays high while running.
`timescale 1ns/1ps
`default_nettype none
module rtb_prescaler
   import rtb_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       run,
   input  wire logic [2:0] select,
   output logic            tick
);
   logic [6:0] div_reg;
   logic [6:0] mask;

   // Divisor 2^select: tick when the low select bits are all ones
   always_comb begin
      mask = 7'((8'h01 << select) - 8'h01);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_reg <= RTB_RST_PRESCALE;
      end else if (!run) begin
         div_reg <= RTB_RST_PRESCALE;
      end else begin
         div_reg <= div_reg + 7'h01;
      end
   end

   always_comb begin
      tick = run && ((div_reg & mask) == mask);
   end
endmodule
`default_nettype wire

// File: rtl/rtb_timer.sv
// Reload timer with baud select options and an AXI4-Lite register port.
// Assumes aclk is the timer clock and software serves the interrupt.
//
// Operation
// - Counter overflow sets control bit 4
// - Service entry clears overflow flag in hardware
// - Software writes set or clear overflow flag
// - Bit 3 halts (0) or runs (1) counter
// - Prescale code divides clock by 2^code
// - Low reload byte gives reload bits 7:0
// - High reload byte gives reload bits 15:8
// - Bit 5 picks first port baud timer
// - Bit 7 doubles second port mode 2 baud
// - Bit 6 steers second port bit 7 access
`timescale 1ns/1ps
`default_nettype none
module rtb_timer
   import rtb_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   input  wire logic        isr_enter,
   output logic             overflow_pulse,
   output logic             baud_source_select,
   output logic             second_port_baud_double,
   output logic             framing_error_access_select,
   output logic             irq
);
   import rtb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [7:0]  timer_b_control_reg;
   logic [7:0]  timer_b_reload_low_reg;
   logic [7:0]  timer_b_reload_high_reg;
   logic [15:0] count_reg;
   logic [1:0]  irq_stat_reg;
   logic [1:0]  irq_mask_reg;
   logic        ovf_pulse_reg;
   logic        isr_meta_reg;
   logic        isr_sync_reg;
   logic        isr_prev_reg;
   logic        isr_edge;
   logic        tick;
   logic        overflow;
   logic [15:0] reload_value;

   logic        aw_held_reg;
   logic [9:0]  aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        wr_fire;
   logic        wr_hit;
   logic        ovf_wr_set;
   logic        ovf_wr_clr;
   logic        aw_held_next;
   logic        w_held_next;
   logic        bvalid_next;
   logic        rvalid_next;

   logic        run;
   logic [2:0]  prescale_select;

   ////////////////////////////////////////////////////////////////////////
   // Address decode, shared by read and write paths

   function automatic logic [2:0] reg_sel(input logic [9:0] addr);
      if (addr == RTB_ADDR_CONTROL) begin
         reg_sel = 3'd1;
      end else if (addr == RTB_ADDR_RELOAD_LO) begin
         reg_sel = 3'd2;
      end else if (addr == RTB_ADDR_RELOAD_HI) begin
         reg_sel = 3'd3;
      end else if (addr == RTB_ADDR_IRQ_STAT) begin
         reg_sel = 3'd4;
      end else if (addr == RTB_ADDR_IRQ_MASK) begin
         reg_sel = 3'd5;
      end else if (addr == RTB_ADDR_ISR_ACK) begin
         reg_sel = 3'd6;
      end else begin
         reg_sel = 3'd0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order

   always_comb begin
      aw_held_next = !wr_fire &&
                     (aw_held_reg || (s_axi_awvalid && s_axi_awready));
      w_held_next  = !wr_fire &&
                     (w_held_reg || (s_axi_wvalid && s_axi_wready));
      bvalid_next  = wr_fire || (s_axi_bvalid && !s_axi_bready);
   end

   // Readies registered from each channel's next state, same timing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end else begin
         s_axi_awready <= !aw_held_next && !bvalid_next;
         s_axi_wready  <= !w_held_next && !bvalid_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 10'h000;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
   end

   always_comb begin
      wr_fire = aw_held_reg && w_held_reg;
      wr_hit  = wr_fire && w_strb_reg[0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RTB_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (reg_sel(aw_addr_reg) == 3'd0) ?
                         RTB_RESP_SLVERR : RTB_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register

   always_comb begin
      run             = timer_b_control_reg[RTB_BIT_RUN];
      prescale_select = timer_b_control_reg[RTB_BIT_PS_LSB +: 3];
      ovf_wr_set = wr_hit && reg_sel(aw_addr_reg) == 3'd1 &&
                   w_data_reg[RTB_BIT_OVF];
      ovf_wr_clr = wr_hit && reg_sel(aw_addr_reg) == 3'd1 &&
                   !w_data_reg[RTB_BIT_OVF];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_b_control_reg <= RTB_RST_CONTROL;
      end else begin
         if (wr_hit && reg_sel(aw_addr_reg) == 3'd1) begin
            timer_b_control_reg[RTB_BIT_DOUBLE]   <=
               w_data_reg[RTB_BIT_DOUBLE];
            timer_b_control_reg[RTB_BIT_FE_SEL]   <=
               w_data_reg[RTB_BIT_FE_SEL];
            timer_b_control_reg[RTB_BIT_BAUD_SRC] <=
               w_data_reg[RTB_BIT_BAUD_SRC];
            timer_b_control_reg[RTB_BIT_RUN]      <=
               w_data_reg[RTB_BIT_RUN];
            timer_b_control_reg[RTB_BIT_PS_LSB +: 3] <=
               w_data_reg[RTB_BIT_PS_LSB +: 3];
         end
         // Hardware overflow beats any clear in the same cycle
         if (overflow) begin
            timer_b_control_reg[RTB_BIT_OVF] <= 1'b1;
         end else if (ovf_wr_set) begin
            timer_b_control_reg[RTB_BIT_OVF] <= 1'b1;
         end else if (ovf_wr_clr || isr_edge) begin
            timer_b_control_reg[RTB_BIT_OVF] <= 1'b0;
         end
      end
   end

   // Reload bytes: a write while running is accepted as is
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_b_reload_low_reg  <= RTB_RST_RELOAD;
         timer_b_reload_high_reg <= RTB_RST_RELOAD;
      end else if (wr_hit) begin
         if (reg_sel(aw_addr_reg) == 3'd2) begin
            timer_b_reload_low_reg <= w_data_reg[7:0];
         end else if (reg_sel(aw_addr_reg) == 3'd3) begin
            timer_b_reload_high_reg <= w_data_reg[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Service-entry strobe from the core, synchronised and edge detected

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         isr_meta_reg <= 1'b0;
         isr_sync_reg <= 1'b0;
         isr_prev_reg <= 1'b0;
      end else begin
         isr_meta_reg <= isr_enter;
         isr_sync_reg <= isr_meta_reg;
         isr_prev_reg <= isr_sync_reg;
      end
   end

   always_comb begin
      isr_edge = (isr_sync_reg && !isr_prev_reg) ||
                 (wr_hit && reg_sel(aw_addr_reg) == 3'd6 &&
                  w_data_reg[0]);
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter

   rtb_prescaler u_prescaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (run),
      .select  (prescale_select),
      .tick    (tick)
   );

   always_comb begin
      reload_value = {timer_b_reload_high_reg,
                      timer_b_reload_low_reg};
      overflow     = tick && (count_reg == RTB_COUNT_MAX);
   end

   // Bytes may be written while running; the count loads the new reload value at the next overflow
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= RTB_RST_COUNT;
      end else if (overflow) begin
         count_reg <= reload_value;
      end else if (tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask, status cleared by writing one

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_reg <= RTB_RST_IRQ;
         irq_mask_reg <= RTB_RST_IRQ;
      end else begin
         if (wr_hit && reg_sel(aw_addr_reg) == 3'd5) begin
            irq_mask_reg <= w_data_reg[1:0];
         end
         irq_stat_reg[1] <= 1'b0;
         if (overflow) begin
            irq_stat_reg[RTB_IRQ_OVF] <= 1'b1;
         end else if (wr_hit && reg_sel(aw_addr_reg) == 3'd4 &&
                      w_data_reg[RTB_IRQ_OVF]) begin
            irq_stat_reg[RTB_IRQ_OVF] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq                         <= 1'b0;
         overflow_pulse              <= 1'b0;
         baud_source_select          <= 1'b0;
         second_port_baud_double     <= 1'b0;
         framing_error_access_select <= 1'b0;
      end else begin
         irq            <= |(irq_stat_reg & irq_mask_reg);
         overflow_pulse <= overflow;
         baud_source_select <= timer_b_control_reg[RTB_BIT_BAUD_SRC];
         second_port_baud_double <=
            timer_b_control_reg[RTB_BIT_DOUBLE];
         framing_error_access_select <=
            timer_b_control_reg[RTB_BIT_FE_SEL];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one cycle from address to data

   always_comb begin
      rvalid_next = (s_axi_arvalid && s_axi_arready) ||
                    (s_axi_rvalid && !s_axi_rready);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
      end else begin
         s_axi_arready <= !rvalid_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RTB_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RTB_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         case (reg_sel(s_axi_araddr))
            3'd1: s_axi_rdata[7:0] <= timer_b_control_reg;
            3'd2: s_axi_rdata[7:0] <= timer_b_reload_low_reg;
            3'd3: s_axi_rdata[7:0] <= timer_b_reload_high_reg;
            3'd4: s_axi_rdata[1:0] <= irq_stat_reg;
            3'd5: s_axi_rdata[1:0] <= irq_mask_reg;
            3'd6: s_axi_rdata[15:0] <= count_reg;
            default: s_axi_rresp <= RTB_RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// File: dv/rtb_timer_monitor.sv
// Checker for the reload timer register bus and option outputs.
// Assumes it is bound to rtb_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rtb_timer_monitor
   import rtb_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [9:0]  s_axi_awaddr,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        baud_source_select,
   input wire logic        second_port_baud_double,
   input wire logic        framing_error_access_select
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ctl_take;
      wr_take ##0 (s_axi_awaddr == RTB_ADDR_CONTROL && s_axi_wstrb[0]);
   endsequence
   a_write_answer: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after take");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   a_aw_blocked: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   a_rdata_upper: assert property (s_axi_rvalid
      |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("read data upper bits not zero");
   a_option_copy: assert property (ctl_take |-> ##3
      {second_port_baud_double, framing_error_access_select,
       baud_source_select} == $past(s_axi_wdata[7:5], 3))
      else $error("option outputs do not follow control write");
endmodule
bind rtb_timer rtb_timer_monitor mon (.*);
`default_nettype wire

// File: dv/rtb_timer_tb.sv
// Self-checking bench for rtb_timer driven over AXI4-Lite.
// Assumes the bound monitor and the rtb_pkg address map.
`timescale 1ns/1ps
`default_nettype none
module rtb_timer_tb;
   import rtb_pkg::*;
   logic        aclk, aresetn, isr_enter, s_axi_bready, s_axi_rready;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic   s_axi_rvalid, overflow_pulse, baud_source_select, irq;
   wire logic   second_port_baud_double, framing_error_access_select;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int bad_count = 0;
   int checked = 0;
   rtb_timer dut (.*);
   initial begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 40);
      chk("bvalid", 1, s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
   endtask
   task automatic rd(input logic [9:0] a, input logic [1:0] er,
                     output logic [31:0] q);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 40);
      chk("rvalid", 1, s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      q = s_axi_rdata;
      chk("rresp", er, s_axi_rresp);
   endtask
   task automatic rc(input string nm, input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      rd(a, RTB_RESP_OKAY, q);
      chk(nm, e, q);
   endtask
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (!overflow_pulse && n < 70000);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      rc("control", RTB_ADDR_CONTROL, 32'h0000_0000);
      rc("reload_low", RTB_ADDR_RELOAD_LO, 32'h0000_0000);
      rc("reload_high", RTB_ADDR_RELOAD_HI, 32'h0000_0000);
      rc("count", RTB_ADDR_ISR_ACK, 32'h0000_0000);
      chk("irq", 0, irq);
      rd(10'h3FC, RTB_RESP_SLVERR, q);
      chk("unmapped", 0, q);
      wr(10'h3FC, 32'h0000_00FF, RTB_RESP_SLVERR);
      $display("t_regs done");
   endtask
   task automatic t_fields();
      for (int v = 0; v < 8; v++) begin
         wr(RTB_ADDR_CONTROL, 32'(v) << 5, RTB_RESP_OKAY);
         chk("options", 32'(v), {second_port_baud_double,
             framing_error_access_select, baud_source_select});
         rc("control", RTB_ADDR_CONTROL, 32'(v) << 5);
      end
      wr(RTB_ADDR_CONTROL, 32'h0000_0010, RTB_RESP_OKAY);
      rc("flag_set", RTB_ADDR_CONTROL, 32'h0000_0010);
      wr(RTB_ADDR_CONTROL, 32'h0000_0000, RTB_RESP_OKAY);
      rc("flag_clear", RTB_ADDR_CONTROL, 32'h0000_0000);
      s_axi_wstrb <= 4'hE;
      wr(RTB_ADDR_CONTROL, 32'h0000_00F0, RTB_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rc("strobe_off", RTB_ADDR_CONTROL, 32'h0000_0000);
      $display("t_fields done");
   endtask
   task automatic t_overflow();
      int n;
      wr(RTB_ADDR_RELOAD_LO, 32'h0000_00FE, RTB_RESP_OKAY);
      wr(RTB_ADDR_RELOAD_HI, 32'h0000_00FF, RTB_RESP_OKAY);
      rc("reload_low", RTB_ADDR_RELOAD_LO, 32'h0000_00FE);
      rc("reload_high", RTB_ADDR_RELOAD_HI, 32'h0000_00FF);
      wr(RTB_ADDR_IRQ_MASK, 32'h0000_0001, RTB_RESP_OKAY);
      wr(RTB_ADDR_CONTROL, 32'h0000_0008, RTB_RESP_OKAY);
      wait_pulse(n);
      chk("pulse", 1, overflow_pulse);
      rc("flag", RTB_ADDR_CONTROL, 32'h0000_0018);
      chk("irq", 1, irq);
      for (int p = 0; p < 8; p++) begin
         wr(RTB_ADDR_CONTROL, 32'h0000_0000, RTB_RESP_OKAY);
         wr(RTB_ADDR_CONTROL, 32'h0000_0008 | p, RTB_RESP_OKAY);
         wait_pulse(n);
         wait_pulse(n);
         chk("period", 2 << p, n);
      end
      $display("t_overflow done");
   endtask
   task automatic t_irq();
      wr(RTB_ADDR_CONTROL, 32'h0000_0010, RTB_RESP_OKAY);
      chk("irq", 1, irq);
      wr(RTB_ADDR_IRQ_MASK, 32'h0000_0000, RTB_RESP_OKAY);
      chk("irq_masked", 0, irq);
      wr(RTB_ADDR_IRQ_MASK, 32'h0000_0001, RTB_RESP_OKAY);
      chk("irq_unmasked", 1, irq);
      wr(RTB_ADDR_IRQ_STAT, 32'h0000_0001, RTB_RESP_OKAY);
      chk("irq_cleared", 0, irq);
      rc("status", RTB_ADDR_IRQ_STAT, 32'h0000_0000);
      isr_enter <= 1'b1;
      repeat (6) @(posedge aclk);
      isr_enter <= 1'b0;
      rc("isr_clear", RTB_ADDR_CONTROL, 32'h0000_0000);
      wr(RTB_ADDR_CONTROL, 32'h0000_0010, RTB_RESP_OKAY);
      wr(RTB_ADDR_ISR_ACK, 32'h0000_0001, RTB_RESP_OKAY);
      rc("ack_clear", RTB_ADDR_CONTROL, 32'h0000_0000);
      $display("t_irq done");
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge aclk);
      bad_count++;
      test_done();
   end
   initial begin
      {aresetn, isr_enter, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
      {s_axi_bready, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_fields();
      t_overflow();
      t_irq();
      test_done();
   end
endmodule
`default_nettype wire
